// ===== rtl/ubfe_engine.sv
`timescale 1ns/10ps
`include "ubfe_defines.svh"

module ubfe_engine #(
   parameter int DATA_W = 8
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [15:0] bus_addr,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   input  wire logic [7:0]  bus_wdata,
   output logic      [7:0]  bus_rdata_q,
   input  wire logic        tx_done_flag_clr,
   input  wire logic        serial_in_pin,
   output logic             serial_out_q,
   output logic             tx_done_request_q,
   output logic             tx_done_flag_q,
   output logic             rx_done_request_q,
   output logic             rx_error_request_q
);

   generate
      if (DATA_W != 8) begin : g_bad_width
         $error("ubfe_engine serves 8-bit characters only");
      end
   endgenerate

   ubfe_pkg::ubfe_mode_t     mode_q;
   ubfe_pkg::ubfe_baud_t     baud_q;
   ubfe_pkg::ubfe_status_t   status_q;
   ubfe_pkg::ubfe_tx_state_t tx_state_q;
   ubfe_pkg::ubfe_rx_state_t rx_state_q;

   logic [7:0] pre_q;
   logic [7:0] pre_mask;
   logic       src_tick;
   logic [7:0] rx_buffer_q;
   logic       rx_full_q;
   logic [7:0] tx_shift_q;
   logic [3:0] tx_cnt_q;
   logic       tx_par_q;
   logic [7:0] rx_shift_q;
   logic [3:0] rx_cnt_q;
   logic       rx_par_q;
   logic       rx_done_pend_q;
   logic       tx_tick;
   logic       rx_tick;
   logic       tx_restart;
   logic       rx_restart;
   logic       rx_half;
   logic       wr_mode;
   logic       wr_baud;
   logic       wr_tx;
   logic       rd_rxb;
   logic [3:0] char_len;
   logic [7:0] tx_char;
   logic       tx_par_bit;
   logic       rx_par_err;
   logic       rx_frame_end;
   logic       rx_any_err;
   logic [3:0] div_eff;

   assign wr_mode = bus_wr && (bus_addr == `UBFE_ADDR_MODE);
   assign wr_baud = bus_wr && (bus_addr == `UBFE_ADDR_BAUD);
   assign wr_tx   = bus_wr && (bus_addr == `UBFE_ADDR_DATA);
   assign rd_rxb  = bus_rd && (bus_addr == `UBFE_ADDR_DATA);

   assign char_len = mode_q.char8 ? `UBFE_CHAR_LEN8 : `UBFE_CHAR_LEN7; // R9

   // bit 7 of the character is dropped in 7-bit mode
   assign tx_char = mode_q.char8 ? bus_wdata
                                 : {1'b0, bus_wdata[`UBFE_DATA_MSB-1:0]}; // R10

   always_comb begin
      unique case (mode_q.parity)
         ubfe_pkg::UBFE_PAR_EVEN: tx_par_bit = ^tx_char;  // R11
         ubfe_pkg::UBFE_PAR_ODD:  tx_par_bit = ~^tx_char; // R12
         ubfe_pkg::UBFE_PAR_ZERO: tx_par_bit = 1'b0;      // R13
         ubfe_pkg::UBFE_PAR_NONE: tx_par_bit = 1'b0;      // R14
      endcase
   end

   always_comb begin
      unique case (mode_q.parity)
         ubfe_pkg::UBFE_PAR_EVEN: rx_par_err = ^{rx_shift_q, rx_par_q};  // R11
         ubfe_pkg::UBFE_PAR_ODD:  rx_par_err = ~^{rx_shift_q, rx_par_q}; // R12
         ubfe_pkg::UBFE_PAR_ZERO: rx_par_err = 1'b0; // R13
         ubfe_pkg::UBFE_PAR_NONE: rx_par_err = 1'b0; // R14
      endcase
   end

   // register writes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_q <= ubfe_pkg::ubfe_mode_t'(`UBFE_MODE_RESET);
         baud_q <= ubfe_pkg::ubfe_baud_t'(`UBFE_BAUD_RESET); // R7
      end else begin
         if (wr_mode) begin
            mode_q <= ubfe_pkg::ubfe_mode_t'(bus_wdata & `UBFE_MODE_WMASK);
         end
         if (wr_baud) begin
            baud_q <= ubfe_pkg::ubfe_baud_t'(bus_wdata & `UBFE_BAUD_WMASK); // R7
         end
      end
   end

   // register reads, one cycle after the strobe
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bus_rdata_q <= 8'h00;
      end else if (bus_rd) begin
         unique case (bus_addr)
            `UBFE_ADDR_MODE:   bus_rdata_q <= mode_q;
            `UBFE_ADDR_STATUS: bus_rdata_q <= {1'b0, status_q};
            `UBFE_ADDR_BAUD:   bus_rdata_q <= baud_q;
            `UBFE_ADDR_DATA:   bus_rdata_q <= rx_buffer_q;
            default:           bus_rdata_q <= 8'h00;
         endcase
      end
   end

   // prescaler: one source tick every 2^(n+1) clocks
   assign pre_mask = 8'((9'h002 << baud_q.prescale) - 9'h001); // R4
   assign src_tick = ((pre_q & pre_mask) == pre_mask);         // R6

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pre_q <= 8'h00;
      end else begin
         pre_q <= pre_q + 8'h01;
      end
   end

   // a prohibited divisor is clamped to 14, a bit period of 30 source ticks
   assign div_eff = (baud_q.divisor == `UBFE_DIV_PROHIB) ? 4'he
                                                         : baud_q.divisor;

   ubfe_bit_timer u_tx_timer (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .src_tick (src_tick),
      .restart  (tx_restart),
      .half     (1'b0),
      .divisor  (div_eff),
      .tick_q   (tx_tick)
   );

   ubfe_bit_timer u_rx_timer (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .src_tick (src_tick),
      .restart  (rx_restart),
      .half     (rx_half),
      .divisor  (div_eff),
      .tick_q   (rx_tick)
   );

   // transmitter; writes while busy are ignored
   assign tx_restart = wr_tx && mode_q.tx_en
                       && (tx_state_q == ubfe_pkg::UBFE_TX_IDLE); // R15

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_state_q        <= ubfe_pkg::UBFE_TX_IDLE;
         tx_shift_q        <= 8'h00;
         tx_cnt_q          <= 4'h0;
         tx_par_q          <= 1'b0;
         serial_out_q      <= 1'b1;
         tx_done_request_q <= 1'b0;
      end else begin
         tx_done_request_q <= 1'b0;
         unique case (tx_state_q)
            ubfe_pkg::UBFE_TX_IDLE: begin
               serial_out_q <= 1'b1;
               if (tx_restart) begin
                  tx_shift_q   <= tx_char;
                  tx_par_q     <= tx_par_bit;
                  tx_cnt_q     <= 4'h0;
                  serial_out_q <= 1'b0; // R15
                  tx_state_q   <= ubfe_pkg::UBFE_TX_START;
               end
            end
            ubfe_pkg::UBFE_TX_START: begin
               if (tx_tick) begin
                  serial_out_q <= tx_shift_q[0]; // R25
                  tx_shift_q   <= {1'b0, tx_shift_q[7:1]};
                  tx_cnt_q     <= 4'h1;
                  tx_state_q   <= ubfe_pkg::UBFE_TX_DATA;
               end
            end
            ubfe_pkg::UBFE_TX_DATA: begin
               if (tx_tick) begin
                  if (tx_cnt_q == char_len) begin
                     tx_cnt_q <= 4'h0;
                     if (mode_q.parity == ubfe_pkg::UBFE_PAR_NONE) begin
                        serial_out_q <= 1'b1; // R14
                        tx_state_q   <= ubfe_pkg::UBFE_TX_STOP;
                     end else begin
                        serial_out_q <= tx_par_q;
                        tx_state_q   <= ubfe_pkg::UBFE_TX_PARITY;
                     end
                  end else begin
                     serial_out_q <= tx_shift_q[0];
                     tx_shift_q   <= {1'b0, tx_shift_q[7:1]};
                     tx_cnt_q     <= tx_cnt_q + 4'h1;
                  end
               end
            end
            ubfe_pkg::UBFE_TX_PARITY: begin
               if (tx_tick) begin
                  serial_out_q <= 1'b1;
                  tx_state_q   <= ubfe_pkg::UBFE_TX_STOP;
               end
            end
            ubfe_pkg::UBFE_TX_STOP: begin
               if (tx_tick) begin
                  if (mode_q.stop_length_sel && tx_cnt_q == 4'h0) begin
                     tx_cnt_q <= 4'h1; // R9
                  end else begin
                     tx_done_request_q <= 1'b1; // R16
                     tx_state_q        <= ubfe_pkg::UBFE_TX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // request flag: a new completion wins over the clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_done_flag_q <= 1'b0;
      end else if (tx_done_request_q) begin
         tx_done_flag_q <= 1'b1; // R16
      end else if (tx_done_flag_clr) begin
         tx_done_flag_q <= 1'b0;
      end
   end

   // receiver; the serial input is already synchronous
   assign rx_half = (rx_state_q == ubfe_pkg::UBFE_RX_IDLE);
   assign rx_restart = mode_q.rx_enable_bit && !serial_in_pin
                       && ((rx_state_q == ubfe_pkg::UBFE_RX_IDLE)
                           || (rx_state_q == ubfe_pkg::UBFE_RX_START
                               && rx_tick)); // R19
   // only one stop bit is sampled, whatever the stop length
   assign rx_frame_end = mode_q.rx_enable_bit && rx_tick
                         && (rx_state_q == ubfe_pkg::UBFE_RX_STOP); // R2
   assign rx_any_err = rx_par_err || !serial_in_pin || rx_full_q;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_state_q <= ubfe_pkg::UBFE_RX_IDLE;
         rx_shift_q <= 8'h00;
         rx_cnt_q   <= 4'h0;
         rx_par_q   <= 1'b0;
      end else if (!mode_q.rx_enable_bit) begin
         rx_state_q <= ubfe_pkg::UBFE_RX_IDLE; // R24
      end else begin
         unique case (rx_state_q)
            ubfe_pkg::UBFE_RX_IDLE: begin
               if (!serial_in_pin) begin
                  rx_state_q <= ubfe_pkg::UBFE_RX_START; // R18
               end
            end
            ubfe_pkg::UBFE_RX_START: begin
               if (rx_tick) begin
                  // a glitch shorter than half a bit is no start bit
                  if (!serial_in_pin) begin
                     rx_shift_q <= 8'h00;
                     rx_cnt_q   <= 4'h0;
                     rx_state_q <= ubfe_pkg::UBFE_RX_DATA; // R19
                  end else begin
                     rx_state_q <= ubfe_pkg::UBFE_RX_IDLE;
                  end
               end
            end
            ubfe_pkg::UBFE_RX_DATA: begin
               if (rx_tick) begin
                  rx_shift_q[rx_cnt_q[2:0]] <= serial_in_pin; // R25 R26
                  rx_cnt_q <= rx_cnt_q + 4'h1;
                  if (rx_cnt_q == char_len - 4'h1) begin
                     if (mode_q.parity == ubfe_pkg::UBFE_PAR_NONE) begin
                        rx_state_q <= ubfe_pkg::UBFE_RX_STOP; // R14
                     end else begin
                        rx_state_q <= ubfe_pkg::UBFE_RX_PARITY;
                     end
                  end
               end
            end
            ubfe_pkg::UBFE_RX_PARITY: begin
               if (rx_tick) begin
                  rx_par_q   <= serial_in_pin;
                  rx_state_q <= ubfe_pkg::UBFE_RX_STOP;
               end
            end
            ubfe_pkg::UBFE_RX_STOP: begin
               if (rx_tick) begin
                  rx_state_q <= ubfe_pkg::UBFE_RX_IDLE; // R20
               end
            end
         endcase
      end
   end

   // buffer, status and overrun; a frame end wins over a buffer read
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_buffer_q <= 8'h00;
         rx_full_q   <= 1'b0;
         status_q    <= '0;
      end else if (rx_frame_end) begin
         rx_buffer_q          <= rx_shift_q; // R21 R10
         rx_full_q            <= 1'b1;
         status_q.parity_err  <= rx_par_err; // R22
         status_q.framing_err <= !serial_in_pin;
         // an unread buffer keeps flagging overrun on every frame
         status_q.overrun_flag <= rx_full_q; // R1 R3
      end else if (rd_rxb) begin
         rx_full_q <= 1'b0;
         status_q  <= '0; // R22
      end
   end

   // error request first, completion request one cycle later
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_error_request_q <= 1'b0;
         rx_done_pend_q     <= 1'b0;
         rx_done_request_q  <= 1'b0;
      end else begin
         rx_error_request_q <= rx_frame_end && rx_any_err; // R23
         rx_done_pend_q     <= rx_frame_end
                               && !(rx_any_err
                                    && mode_q.error_irq_suppress); // R21
         rx_done_request_q  <= rx_done_pend_q; // R23
      end
   end

endmodule

// ===== rtl/ubfe_defines.svh
// Operation
// R1: overrun when frame ends with buffer unread
// R2: receiver checks only one stop bit
// R3: software must read buffer after overrun
// R4: source clock is main clock over 2^(n+1)
// R5: bit period is 16+k source clocks
// R6: bit rate equals fx/(2^(n+1)*(k+16))
// R7: baud register resets zero, bit7 zero
// R8: software never writes baud register mid-transfer
// R9: start, 7/8 bits, parity, 1/2 stops
// R10: 7-bit mode drops/zeroes bit 7
// R11: even parity generated and checked
// R12: odd parity generated and checked
// R13: zero parity sends 0, never checks
// R14: no parity sends none, checks none
// R15: tx register write starts framed transmission
// R16: shift-out end raises done request and flag
// R17: software never rewrites mode during transmission
// R18: receive enable starts input sampling
// R19: start bit confirmed at half-bit strobe
// R20: frame ends after data, parity, stop
// R21: buffer loaded at end, done unless suppressed
// R22: error flags cleared on read or next frame
// R23: error request precedes done request
// R24: receive disable aborts frame without effects
// R25: character bits travel LSB first
// R26: later bits sampled once per bit period
`ifndef UBFE_DEFINES_SVH
`define UBFE_DEFINES_SVH

`define UBFE_ADDR_MODE     16'hffa0
`define UBFE_ADDR_STATUS   16'hffa1
`define UBFE_ADDR_BAUD     16'hffa2
`define UBFE_ADDR_DATA     16'hffa3

`define UBFE_MODE_RESET    8'h00
`define UBFE_BAUD_RESET    8'h00
`define UBFE_MODE_WMASK    8'hfe
`define UBFE_BAUD_WMASK    8'h7f

`define UBFE_BAUD_PS_LSB   4
`define UBFE_BAUD_PS_MSB   6
`define UBFE_BAUD_DIV_MSB  3
`define UBFE_DIV_BASE      5'h10
`define UBFE_DIV_PROHIB    4'hf

`define UBFE_CHAR_LEN7     4'h7
`define UBFE_CHAR_LEN8     4'h8
`define UBFE_DATA_MSB      7

`endif

// ===== rtl/ubfe_pkg.sv
package ubfe_pkg;

   typedef enum logic [1:0] {
      UBFE_PAR_NONE = 2'h0,
      UBFE_PAR_ZERO = 2'h1,
      UBFE_PAR_ODD  = 2'h2,
      UBFE_PAR_EVEN = 2'h3
   } ubfe_parity_t;

   typedef struct packed {
      logic         tx_en;
      logic         rx_enable_bit;
      ubfe_parity_t parity;
      logic         char8;
      logic         stop_length_sel;
      logic         error_irq_suppress;
      logic         rsvd;
   } ubfe_mode_t;

   typedef struct packed {
      logic [3:0] rsvd;
      logic       parity_err;
      logic       framing_err;
      logic       overrun_flag;
   } ubfe_status_t;

   typedef struct packed {
      logic       rsvd;
      logic [2:0] prescale;
      logic [3:0] divisor;
   } ubfe_baud_t;

   typedef enum logic [4:0] {
      UBFE_TX_IDLE   = 5'b00001,
      UBFE_TX_START  = 5'b00010,
      UBFE_TX_DATA   = 5'b00100,
      UBFE_TX_PARITY = 5'b01000,
      UBFE_TX_STOP   = 5'b10000
   } ubfe_tx_state_t;

   typedef enum logic [4:0] {
      UBFE_RX_IDLE   = 5'b00001,
      UBFE_RX_START  = 5'b00010,
      UBFE_RX_DATA   = 5'b00100,
      UBFE_RX_PARITY = 5'b01000,
      UBFE_RX_STOP   = 5'b10000
   } ubfe_rx_state_t;

endpackage

// ===== rtl/ubfe_bit_timer.sv
`timescale 1ns/10ps
`include "ubfe_defines.svh"

module ubfe_bit_timer (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       src_tick,
   input  wire logic       restart,
   input  wire logic       half,
   input  wire logic [3:0] divisor,
   output logic            tick_q
);

   logic [4:0] cnt_q;
   logic       half_q;
   logic [4:0] period;
   logic [4:0] limit;

   assign period = `UBFE_DIV_BASE + {1'b0, divisor}; // R5
   assign limit  = half_q ? {1'b0, period[4:1]} : period;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q  <= 5'h00;
         half_q <= 1'b0;
         tick_q <= 1'b0;
      end else if (restart) begin
         cnt_q  <= 5'h00;
         half_q <= half;
         tick_q <= 1'b0;
      end else if (src_tick) begin
         if (cnt_q == limit - 5'h01) begin
            cnt_q  <= 5'h00;
            half_q <= 1'b0; // R26
            tick_q <= 1'b1;
         end else begin
            cnt_q  <= cnt_q + 5'h01;
            tick_q <= 1'b0;
         end
      end else begin
         tick_q <= 1'b0;
      end
   end

endmodule

// ===== sim/ubfe_chk.sv
`timescale 1ns/10ps
`include "ubfe_defines.svh"

module ubfe_chk #(
   parameter int DATA_W = 8
) (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [15:0] bus_addr,
   input wire logic        bus_wr,
   input wire logic        bus_rd,
   input wire logic [7:0]  bus_wdata,
   input wire logic [7:0]  bus_rdata_q,
   input wire logic        tx_done_flag_clr,
   input wire logic        serial_in_pin,
   input wire logic        serial_out_q,
   input wire logic        tx_done_request_q,
   input wire logic        tx_done_flag_q,
   input wire logic        rx_done_request_q,
   input wire logic        rx_error_request_q
);
   logic [7:0] mode_q, baud_q;
   logic       busy_q, take_w;

   // data write counts only when idle
   assign take_w = bus_wr && bus_addr == `UBFE_ADDR_DATA && mode_q[7] &&
                   !busy_q;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_q <= 8'h00;
         baud_q <= 8'h00;
         busy_q <= 1'b0;
      end else begin
         if (bus_wr && bus_addr == `UBFE_ADDR_MODE)
            mode_q <= bus_wdata & `UBFE_MODE_WMASK;
         if (bus_wr && bus_addr == `UBFE_ADDR_BAUD)
            baud_q <= bus_wdata & `UBFE_BAUD_WMASK;
         if (take_w)
            busy_q <= 1'b1;
         else if (tx_done_request_q)
            busy_q <= 1'b0;
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   tx_req_pulse_a: assert property (tx_done_request_q |=>
      !tx_done_request_q) else $error("tx request too long");
   tx_flag_set_a: assert property (tx_done_request_q |=>
      tx_done_flag_q) else $error("tx flag not set");
   flag_clear_a: assert property (tx_done_flag_clr &&
      !tx_done_request_q |=> !tx_done_flag_q) else $error("flag not clear");
   tx_start_a: assert property (take_w |-> ##[1:2]
      !serial_out_q) else $error("no start bit");
   tx_idle_a: assert property (!busy_q |-> serial_out_q)
      else $error("line not idle high");
   baud_read_a: assert property (bus_rd &&
      bus_addr == `UBFE_ADDR_BAUD |=> bus_rdata_q == baud_q)
      else $error("baud readback wrong");
   unmapped_read_a: assert property (bus_rd &&
      (bus_addr < `UBFE_ADDR_MODE || bus_addr > `UBFE_ADDR_DATA)
      |=> bus_rdata_q == 8'h00) else $error("unmapped read not zero");
   err_then_done_a: assert property (rx_error_request_q |=>
      rx_done_request_q == !mode_q[1]) else $error("done after error");
   err_first_a: assert property (rx_error_request_q |->
      !rx_done_request_q) else $error("done with error");
   rx_done_pulse_a: assert property (rx_done_request_q |=>
      !rx_done_request_q) else $error("rx request too long");
endmodule

bind ubfe_engine ubfe_chk #(.DATA_W(DATA_W)) chk_u (
   .clk_sys            (clk_sys),
   .rst                (rst),
   .bus_addr           (bus_addr),
   .bus_wr             (bus_wr),
   .bus_rd             (bus_rd),
   .bus_wdata          (bus_wdata),
   .bus_rdata_q        (bus_rdata_q),
   .tx_done_flag_clr   (tx_done_flag_clr),
   .serial_in_pin      (serial_in_pin),
   .serial_out_q       (serial_out_q),
   .tx_done_request_q  (tx_done_request_q),
   .tx_done_flag_q     (tx_done_flag_q),
   .rx_done_request_q  (rx_done_request_q),
   .rx_error_request_q (rx_error_request_q)
);

// ===== sim/ubfe_far_model.sv
`timescale 1ns/10ps

module ubfe_far_model (
   input  wire logic clk_sys,
   input  wire logic line_in,
   output logic      line_out
);
   int bit_len = 32;

   initial line_out = 1'b1;

   task automatic put(input logic v);
      line_out <= v;
      repeat (bit_len) @(posedge clk_sys);
   endtask

   task automatic send(input logic [7:0] d, input int nb, input bit pon,
                       input logic par, input logic stp);
      put(1'b0);
      for (int i = 0; i < nb; i++)
         put(d[i]);
      if (pon)
         put(par);
      if (stp)
         put(1'b1);
      else begin
         // bad stop kept short so its tail is rejected as a glitch
         line_out <= 1'b0;
         repeat (bit_len * 5 / 8) @(posedge clk_sys);
         put(1'b1);
         put(1'b1);
      end
   endtask

   task automatic glitch(input int n);
      line_out <= 1'b0;
      repeat (n) @(posedge clk_sys);
      put(1'b1);
      repeat (bit_len * 11) @(posedge clk_sys);
   endtask

   task automatic recv(input int nb, input bit pon, output logic [7:0] d,
                       output logic par);
      int w = 0;
      d = 8'h00;
      par = 1'b0;
      while (line_in !== 1'b0 && w < 2000) begin
         @(posedge clk_sys);
         w++;
      end
      repeat (bit_len / 2) @(posedge clk_sys);
      for (int i = 0; i < nb; i++) begin
         repeat (bit_len) @(posedge clk_sys);
         d[i] = line_in;
      end
      if (pon) begin
         repeat (bit_len) @(posedge clk_sys);
         par = line_in;
      end
   endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/10ps
`include "ubfe_defines.svh"

module testbench;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] bus_addr = 16'h0000;
   logic        bus_wr = 1'b0, bus_rd = 1'b0;
   logic [7:0]  bus_wdata = 8'h00;
   logic [7:0]  bus_rdata_q;
   logic        tx_done_flag_clr = 1'b0;
   logic        serial_in_pin, serial_out_q, tx_done_request_q;
   logic        tx_done_flag_q, rx_done_request_q, rx_error_request_q;
   int          n_mismatch = 0, cmp_count = 0;
   int          n_rxd = 0, n_rxe = 0;

   always #2 clk_sys = ~clk_sys;

   ubfe_engine #(.DATA_W(8)) dut_u (
      .clk_sys            (clk_sys),
      .rst                (rst),
      .bus_addr           (bus_addr),
      .bus_wr             (bus_wr),
      .bus_rd             (bus_rd),
      .bus_wdata          (bus_wdata),
      .bus_rdata_q        (bus_rdata_q),
      .tx_done_flag_clr   (tx_done_flag_clr),
      .serial_in_pin      (serial_in_pin),
      .serial_out_q       (serial_out_q),
      .tx_done_request_q  (tx_done_request_q),
      .tx_done_flag_q     (tx_done_flag_q),
      .rx_done_request_q  (rx_done_request_q),
      .rx_error_request_q (rx_error_request_q)
   );

   ubfe_far_model far_u (
      .clk_sys  (clk_sys),
      .line_in  (serial_out_q),
      .line_out (serial_in_pin)
   );

   always @(posedge clk_sys) begin
      if (rx_done_request_q === 1'b1)
         n_rxd <= n_rxd + 1;
      if (rx_error_request_q === 1'b1)
         n_rxe <= n_rxe + 1;
   end

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_rng(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      @(negedge clk_sys);
      cmp8(bus_rdata_q, e);
      @(posedge clk_sys);
   endtask

   task automatic t_regs();
      rd_chk(`UBFE_ADDR_BAUD, 8'h00);
      rd_chk(`UBFE_ADDR_STATUS, 8'h00);
      wr(`UBFE_ADDR_BAUD, 8'hff);
      rd_chk(`UBFE_ADDR_BAUD, 8'h7f);
      wr(`UBFE_ADDR_BAUD, 8'h00);
      rd_chk(16'hffa4, 8'h00);
      $display("t_regs done");
   endtask

   task automatic t_tx();
      logic [7:0] m [4] = '{8'h88, 8'hb0, 8'hac, 8'h98};
      logic [7:0] d, ed;
      logic       p, ep;
      int         n, nb, bits;
      for (int i = 0; i < 4; i++) begin
         nb = m[i][3] ? 8 : 7;
         ed = m[i][3] ? 8'ha5 : 8'h25;
         ep = (m[i][5:4] == 2'h3) ? ^ed : (m[i][5] ? ~^ed : 1'b0);
         bits = 2 + nb + int'(m[i][5:4] != 2'h0) + int'(m[i][2]);
         wr(`UBFE_ADDR_MODE, m[i]);
         n = 0;
         fork
            far_u.recv(nb, m[i][5:4] != 2'h0, d, p);
            begin
               wr(`UBFE_ADDR_DATA, 8'ha5);
               while (tx_done_request_q !== 1'b1 && n < 2000) begin
                  @(negedge clk_sys);
                  n++;
               end
            end
         join
         cmp8(d, ed);
         cmp8({7'h0, p}, {7'h0, ep});
         cmp_rng(n, bits * 32 - 8, bits * 32 + 4);
         @(negedge clk_sys);
         cmp8({7'h0, tx_done_flag_q}, 8'h01);
         @(posedge clk_sys);
         tx_done_flag_clr <= 1'b1;
         @(posedge clk_sys);
         tx_done_flag_clr <= 1'b0;
         @(negedge clk_sys);
         cmp8({7'h0, tx_done_flag_q}, 8'h00);
         @(posedge clk_sys);
      end
      $display("t_tx done");
   endtask

   task automatic t_rate();
      int n = 0;
      wr(`UBFE_ADDR_BAUD, 8'h13);
      wr(`UBFE_ADDR_MODE, 8'h88);
      wr(`UBFE_ADDR_DATA, 8'ha5);
      while (serial_out_q === 1'b0 && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      cmp_rng(n, 72, 80);
      // frame must end before the divider changes
      repeat (1000) @(posedge clk_sys);
      wr(`UBFE_ADDR_BAUD, 8'h00);
      $display("t_rate done");
   endtask

   task automatic t_rx_par();
      logic [7:0] m [5] = '{8'h48, 8'h78, 8'h68, 8'h58, 8'h70};
      logic [7:0] ed;
      logic       gp;
      int         e0;
      for (int i = 0; i < 5; i++) begin
         ed = m[i][3] ? 8'hc3 : 8'h43;
         gp = (m[i][5:4] == 2'h3) ? ^ed : ~^ed;
         wr(`UBFE_ADDR_MODE, m[i]);
         e0 = n_rxe;
         for (int j = 0; j < 2; j++) begin
            far_u.send(ed, m[i][3] ? 8 : 7, m[i][5:4] != 2'h0,
                       gp ^ j[0], 1'b1);
            repeat (4) @(posedge clk_sys);
            rd_chk(`UBFE_ADDR_STATUS, {5'h0, m[i][5] & j[0], 2'h0});
            rd_chk(`UBFE_ADDR_DATA, ed);
         end
         cmp_rng(n_rxe - e0, int'(m[i][5]), int'(m[i][5]));
      end
      $display("t_rx_par done");
   endtask

   task automatic t_rx_err();
      int d0 = n_rxd, e0 = n_rxe;
      wr(`UBFE_ADDR_MODE, 8'h4c);
      far_u.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
      far_u.send(8'h22, 8, 1'b0, 1'b0, 1'b1);
      repeat (4) @(posedge clk_sys);
      rd_chk(`UBFE_ADDR_STATUS, 8'h01);
      rd_chk(`UBFE_ADDR_DATA, 8'h22);
      rd_chk(`UBFE_ADDR_STATUS, 8'h00);
      cmp_rng(n_rxd - d0, 2, 2);
      cmp_rng(n_rxe - e0, 1, 1);
      far_u.send(8'h33, 8, 1'b0, 1'b0, 1'b0);
      far_u.send(8'h44, 8, 1'b0, 1'b0, 1'b1);
      repeat (4) @(posedge clk_sys);
      rd_chk(`UBFE_ADDR_STATUS, 8'h01);
      rd_chk(`UBFE_ADDR_DATA, 8'h44);
      wr(`UBFE_ADDR_MODE, 8'h4e);
      d0 = n_rxd;
      e0 = n_rxe;
      far_u.send(8'h55, 8, 1'b0, 1'b0, 1'b0);
      repeat (4) @(posedge clk_sys);
      rd_chk(`UBFE_ADDR_STATUS, 8'h02);
      rd_chk(`UBFE_ADDR_DATA, 8'h55);
      cmp_rng(n_rxd - d0, 0, 0);
      cmp_rng(n_rxe - e0, 1, 1);
      $display("t_rx_err done");
   endtask

   task automatic t_rx_start();
      int d0 = n_rxd, e0 = n_rxe;
      wr(`UBFE_ADDR_MODE, 8'h48);
      far_u.glitch(8);
      cmp_rng(n_rxd - d0, 0, 0);
      fork
         far_u.send(8'h5a, 8, 1'b0, 1'b0, 1'b1);
         begin
            repeat (100) @(posedge clk_sys);
            wr(`UBFE_ADDR_MODE, 8'h08);
         end
      join
      repeat (4) @(posedge clk_sys);
      cmp_rng(n_rxd + n_rxe - d0 - e0, 0, 0);
      rd_chk(`UBFE_ADDR_STATUS, 8'h00);
      rd_chk(`UBFE_ADDR_DATA, 8'h55);
      wr(`UBFE_ADDR_MODE, 8'h48);
      far_u.send(8'h96, 8, 1'b0, 1'b0, 1'b1);
      repeat (4) @(posedge clk_sys);
      rd_chk(`UBFE_ADDR_DATA, 8'h96);
      cmp_rng(n_rxd - d0, 1, 1);
      $display("t_rx_start done");
   endtask

   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_regs();
      t_tx();
      t_rate();
      t_rx_par();
      t_rx_err();
      t_rx_start();
      give_verdict();
   end

   // run is near 9k cycles; trips only on a hang
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_mismatch++;
      give_verdict();
   end
endmodule
